// File: rtl/tfupv_cmd.sv
// Purpose: interprets file-write and password-check command frames, answers status
// Assumes: frames arrive one byte per rx_i.valid, rx_i.last marks the final byte
// Notes:   memory write is byte by byte, then one commit with a done handshake
`timescale 1ns/1ps
`default_nettype none
`include "tfupv_defines.svh"

module tfupv_cmd
	import tfupv_pkg::*;
#(
	parameter int WTX_CYCLES = 1000  // commit cycles before each extension request
)
(
	input  wire logic            clock_i,        // 125 MHz system clock
	input  wire logic            rst_i,          // synchronous reset, high
	input  wire tfupv_byte_type  rx_i,           // command frame bytes
	input  wire logic            tx_ready_i,     // response sink takes tx_o
	output tfupv_byte_type       tx_o,           // response bytes
	output tfupv_mem_type        mem_o,          // file write port
	input  wire logic            mem_done_i,     // commit finished, one pulse
	input  wire logic            mem_ok_i,       // commit result with mem_done_i
	output logic                 wtx_req_o,      // timing extension request pulse
	input  wire logic            from_i2c_i,     // frame came from the I2C host
	input  wire logic            session_open_i, // new RF session pulse
	input  wire logic            select_i,       // a file select completed, pulse
	input  wire logic            file_sel_i,     // some file is selected
	input  wire logic            ndef_sel_i,     // selected file is an NDEF file
	input  wire logic [15:0]     file_len_i,     // length of the selected file
	input  wire logic            read_prot_i,    // NDEF read needs a password
	input  wire logic            write_prot_i,   // NDEF write needs a password
	input  wire logic [127:0]    read_pwd_i,     // read reference password
	input  wire logic [127:0]    write_pwd_i,    // write reference password
	input  wire logic [127:0]    i2c_pwd_i,      // I2C reference password
	output logic                 read_grant_o,   // read right granted
	output logic                 write_grant_o,  // write right granted
	output logic [3:0]           retries_o       // RF retries left
);

	tfupv_regs_type r;
	tfupv_regs_type next_r;
	logic           pwd_clear;
	logic           pwd_shift;
	logic           pwd_match;
	logic [127:0]   ref_pwd;
	logic           len_ok;

	// header screening, shared by the short-frame and full-header paths
	function automatic logic [15:0] hdr_check(input logic [7:0] cla, input logic [7:0] ins,
		input logic [15:0] p1p2, input logic [7:0] lc);
		logic [16:0] end_pos;
		logic        prot;
		logic        pid_ok;
		end_pos = {1'b0, p1p2} + {9'h000, lc};
		prot    = (p1p2 == `TFUPV_PID_READ) ? (read_prot_i && !r.read_grant) :
			(p1p2 == `TFUPV_PID_WRITE) ? (write_prot_i && !r.write_grant) : 1'b0;
		pid_ok  = (p1p2 == `TFUPV_PID_READ) || (p1p2 == `TFUPV_PID_WRITE) ||
			((p1p2 == `TFUPV_PID_I2C) && from_i2c_i);
		hdr_check = `TFUPV_SW_BAD_INS;
		if (cla != `TFUPV_CLA_STD)
			hdr_check = `TFUPV_SW_CLASS;
		else if (ins == `TFUPV_INS_WRITE)
		begin
			if (!file_sel_i)
				hdr_check = `TFUPV_SW_NOT_FOUND;
			else if (lc < `TFUPV_LC_MIN || lc > `TFUPV_LC_MAX)
				hdr_check = `TFUPV_SW_WRONG_LEN;
			else if (end_pos > {1'b0, file_len_i})
				hdr_check = `TFUPV_SW_WRONG_LEN;
			else if (ndef_sel_i && write_prot_i && !r.write_grant)
				hdr_check = `TFUPV_SW_SECURITY;
			else
				hdr_check = `TFUPV_SW_PROCEED;
		end
		else if (ins == `TFUPV_INS_VERIFY)
		begin
			if (!ndef_sel_i)
				hdr_check = file_sel_i ? `TFUPV_SW_INCOMPAT : `TFUPV_SW_NO_NDEF;
			else if (!pid_ok)
				hdr_check = `TFUPV_SW_BAD_DATA;
			else if (!from_i2c_i && r.retries == 4'h0)
				hdr_check = `TFUPV_SW_SECURITY;
			else if (lc == `TFUPV_LC_NONE)
				hdr_check = prot ? `TFUPV_SW_PWD_REQ : `TFUPV_SW_OK;
			else if (lc == `TFUPV_LC_PWD)
				hdr_check = `TFUPV_SW_PROCEED;
			else
				hdr_check = `TFUPV_SW_BAD_DATA;
		end
	endfunction

	assign ref_pwd = (r.p1p2 == `TFUPV_PID_READ) ? read_pwd_i :
		(r.p1p2 == `TFUPV_PID_I2C) ? i2c_pwd_i : write_pwd_i;

	tfupv_pwd_match #(
		.PWD_BITS (128)
	) u_pwd (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.clear_i (pwd_clear),
		.shift_i (pwd_shift),
		.byte_i  (rx_i.data),
		.ref_i   (ref_pwd),
		.match_o (pwd_match)
	);

	always_comb
	begin
		next_r         = r;
		next_r.mem.we  = 1'b0;
		next_r.mem.commit = 1'b0;
		next_r.wtx     = 1'b0;
		pwd_clear      = 1'b0;
		pwd_shift      = 1'b0;
		len_ok         = 1'b0;
		// a new select drops earlier rights, a new session restores retries unless a failed RF check falls in the same cycle
		if (session_open_i)
		begin
			next_r.retries     = `TFUPV_RF_RETRIES;
			next_r.read_grant  = 1'b0;
			next_r.write_grant = 1'b0;
		end
		else if (select_i)
		begin
			next_r.read_grant  = 1'b0;
			next_r.write_grant = 1'b0;
		end
		unique case (r.state)
			ST_HDR:
				if (rx_i.valid)
				begin
					next_r.idx = r.idx + 3'h1;
					unique case (r.idx)
						3'h0: next_r.cla = rx_i.data;
						3'h1: next_r.ins = rx_i.data;
						3'h2: next_r.p1p2[15:8] = rx_i.data;
						3'h3: next_r.p1p2[7:0] = rx_i.data;
						default: next_r.lc = rx_i.data;
					endcase
					if (r.idx == `TFUPV_HDR_LC_IDX)
					begin
						next_r.sw = hdr_check(r.cla, r.ins, r.p1p2, rx_i.data);
						next_r.dcnt = 8'h00;
						next_r.over = 1'b0;
						if (rx_i.last)
						begin
							if (next_r.sw == `TFUPV_SW_PROCEED)
								next_r.sw = `TFUPV_SW_WRONG_LEN;
							next_r.state = ST_SW1;
						end
						else if (next_r.sw == `TFUPV_SW_PROCEED)
						begin
							next_r.state = ST_DATA;
							pwd_clear    = 1'b1;
						end
						else
							next_r.state = ST_SKIP;
					end
					else if (rx_i.last)
					begin
						// four-byte frame without Lc is screened as if Lc were zero; shorter frames get wrong length
						next_r.sw = (r.idx == `TFUPV_HDR_P2_IDX) ?
							hdr_check(r.cla, r.ins, {r.p1p2[15:8], rx_i.data}, 8'h00) :
							`TFUPV_SW_WRONG_LEN;
						if (next_r.sw == `TFUPV_SW_PROCEED)
							next_r.sw = `TFUPV_SW_WRONG_LEN;
						next_r.state = ST_SW1;
					end
				end
			ST_DATA:
				if (rx_i.valid)
				begin
					// bytes past Lc are dropped, never written
					if (r.dcnt == r.lc)
						next_r.over = 1'b1;
					else
					begin
						next_r.dcnt = r.dcnt + 8'h01;
						if (r.ins == `TFUPV_INS_WRITE)
						begin
							next_r.mem.we    = 1'b1;
							next_r.mem.addr  = r.p1p2 + {8'h00, r.dcnt};
							next_r.mem.wdata = rx_i.data;
						end
						else
							pwd_shift = 1'b1;
					end
					if (rx_i.last)
					begin
						len_ok = !next_r.over && (next_r.dcnt == r.lc);
						if (r.ins == `TFUPV_INS_WRITE)
						begin
							if (len_ok)
							begin
								next_r.state      = ST_COMMIT;
								next_r.mem.commit = 1'b1;
								next_r.wait_cnt   = '0;
							end
							else
							begin
								next_r.sw    = `TFUPV_SW_WRONG_LEN;
								next_r.state = ST_SW1;
							end
						end
						else if (len_ok)
							next_r.state = ST_CHECK;
						else
						begin
							next_r.sw    = `TFUPV_SW_BAD_DATA;
							next_r.state = ST_SW1;
						end
					end
				end
			ST_SKIP:
				if (rx_i.valid && rx_i.last)
					next_r.state = ST_SW1;
			ST_CHECK:
			begin
				next_r.state = ST_SW1;
				if (pwd_match)
				begin
					next_r.sw = `TFUPV_SW_OK;
					if (r.p1p2 != `TFUPV_PID_WRITE)
						next_r.read_grant = 1'b1;
					if (r.p1p2 != `TFUPV_PID_READ)
						next_r.write_grant = 1'b1;
					if (!from_i2c_i)
						next_r.retries = `TFUPV_RF_RETRIES;
				end
				else
				begin
					// only the RF host is limited; I2C failures keep the count
					if (!from_i2c_i)
						next_r.retries = r.retries - 4'h1;
					next_r.sw = {`TFUPV_SW1_RETRY, `TFUPV_SW2_RETRY_HI, next_r.retries};
				end
			end
			ST_COMMIT:
			begin
				next_r.wait_cnt = r.wait_cnt + 32'h1;
				// repeat the extension request every window while memory is busy
				if (r.wait_cnt == 32'(WTX_CYCLES - 1))
				begin
					next_r.wtx      = 1'b1;
					next_r.wait_cnt = '0;
				end
				if (mem_done_i)
				begin
					next_r.sw    = mem_ok_i ? `TFUPV_SW_OK : `TFUPV_SW_UPD_FAIL;
					next_r.state = ST_SW1;
					next_r.wtx   = 1'b0;
				end
			end
			ST_SW1:
				if (tx_ready_i)
				begin
					next_r.tx.data = r.sw[7:0];
					next_r.tx.last = 1'b1;
					next_r.state   = ST_SW2;
				end
			ST_SW2:
				if (tx_ready_i)
				begin
					next_r.tx    = '0;
					next_r.idx   = 3'h0;
					next_r.state = ST_HDR;
				end
		endcase
		if (next_r.state == ST_SW1 && r.state != ST_SW1)
		begin
			next_r.tx.valid = 1'b1;
			next_r.tx.last  = 1'b0;
			next_r.tx.data  = next_r.sw[15:8];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			r         <= '0;
			r.retries <= `TFUPV_RF_RETRIES;
		end
		else
			r <= next_r;
	end

	assign tx_o          = r.tx;
	assign mem_o         = r.mem;
	assign wtx_req_o     = r.wtx;
	assign read_grant_o  = r.read_grant;
	assign write_grant_o = r.write_grant;
	assign retries_o     = r.retries;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_write_only_cmd: assert property (
		r.mem.we |-> (r.ins == `TFUPV_INS_WRITE) && (r.cla == `TFUPV_CLA_STD) && r.state != ST_HDR)
		else $error("memory write outside a file-write");
	a_write_in_range: assert property (
		r.mem.we |-> (r.dcnt <= r.lc) && (r.lc <= `TFUPV_LC_MAX) && (r.lc >= `TFUPV_LC_MIN))
		else $error("memory write beyond Lc");
	a_wtx_in_commit: assert property (
		r.wtx |-> r.state == ST_COMMIT && !r.tx.valid)
		else $error("extension request outside commit");
	a_commit_status: assert property (
		(r.state == ST_COMMIT && mem_done_i) |=>
			r.tx.valid && r.tx.data == (mem_ok_i ? 8'h90 : 8'h65))
		else $error("commit status wrong");
	a_retry_bound: assert property (
		r.retries <= `TFUPV_RF_RETRIES)
		else $error("retry count above limit");
	a_retry_step: assert property (
		(!$past(session_open_i) && r.retries < $past(r.retries)) |->
			r.retries == $past(r.retries) - 4'h1)
		else $error("retry count dropped by more than one");
	a_bad_pwd_sw2: assert property (
		(r.state == ST_CHECK && !pwd_match) ##1 (r.tx.valid && tx_ready_i) |=>
			r.tx.data == {`TFUPV_SW2_RETRY_HI, r.retries})
		else $error("wrong password status low byte");
	a_grant_cause: assert property (
		$rose(r.write_grant) |-> $past(r.state) == ST_CHECK && $past(pwd_match))
		else $error("write right granted without a good password");
	a_sw_pairing: assert property (
		(r.tx.valid && !r.tx.last && tx_ready_i) |=> r.tx.valid && r.tx.last ##1 1'b1)
		else $error("SW2 did not follow SW1");
	a_sw_end: assert property (
		(r.tx.valid && r.tx.last && tx_ready_i) |=> !r.tx.valid && r.state == ST_HDR)
		else $error("response did not end after SW2");

	c_write_ok: cover property (r.state == ST_COMMIT && mem_done_i && mem_ok_i);
	c_wtx: cover property (r.wtx);
	c_pwd_ok: cover property (r.state == ST_CHECK && pwd_match);
	c_pwd_bad: cover property (r.state == ST_CHECK && !pwd_match && !from_i2c_i);

endmodule

`default_nettype wire

// File: rtl/tfupv_defines.svh
// Purpose: constants of the file-write / password-check command interpreter
// Assumes: byte-wide command and response streams
// Notes:   status words are {sw1, sw2}
`ifndef TFUPV_DEFINES_SVH
`define TFUPV_DEFINES_SVH

`define TFUPV_CLA_STD       8'h00
`define TFUPV_INS_WRITE     8'hD6
`define TFUPV_INS_VERIFY    8'h20
`define TFUPV_LC_MIN        8'h01
`define TFUPV_LC_MAX        8'hF6
`define TFUPV_LC_NONE       8'h00
`define TFUPV_LC_PWD        8'h10

`define TFUPV_PID_READ      16'h0001
`define TFUPV_PID_WRITE     16'h0002
`define TFUPV_PID_I2C       16'h0003

`define TFUPV_SW_OK         16'h9000
`define TFUPV_SW_UPD_FAIL   16'h6581
`define TFUPV_SW_WRONG_LEN  16'h6700
`define TFUPV_SW_SECURITY   16'h6982
`define TFUPV_SW_NOT_FOUND  16'h6A82
`define TFUPV_SW_CLASS      16'h6E00
`define TFUPV_SW_BAD_INS    16'h6D00
`define TFUPV_SW_PWD_REQ    16'h6300
`define TFUPV_SW_NO_NDEF    16'h6985
`define TFUPV_SW_INCOMPAT   16'h6981
`define TFUPV_SW_BAD_DATA   16'h6A80
`define TFUPV_SW_PROCEED    16'h0000
`define TFUPV_SW1_RETRY     8'h63
`define TFUPV_SW2_RETRY_HI  4'hC

`define TFUPV_RF_RETRIES    4'h3
`define TFUPV_HDR_LC_IDX    3'h4
`define TFUPV_HDR_P2_IDX    3'h3

`endif

// File: rtl/tfupv_pkg.sv
// Purpose: types of the file-write / password-check command interpreter
// Assumes: nothing beyond the defines header
// Notes:   all carriers are packed structs
package tfupv_pkg;

	typedef enum logic [2:0] {ST_HDR, ST_DATA, ST_SKIP, ST_CHECK, ST_COMMIT, ST_SW1, ST_SW2}
		tfupv_state_type;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} tfupv_byte_type;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        commit;
	} tfupv_mem_type;

	typedef struct packed {
		tfupv_state_type state;
		logic [7:0]      cla;
		logic [7:0]      ins;
		logic [15:0]     p1p2;
		logic [7:0]      lc;
		logic [2:0]      idx;
		logic [7:0]      dcnt;
		logic            over;
		logic [15:0]     sw;
		logic [3:0]      retries;
		logic            read_grant;
		logic            write_grant;
		logic [31:0]     wait_cnt;
		logic            wtx;
		tfupv_mem_type   mem;
		tfupv_byte_type  tx;
	} tfupv_regs_type;

	typedef struct packed {
		logic [127:0] shift;
	} tfupv_pwd_type;

endpackage

// File: rtl/tfupv_pwd_match.sv
// Purpose: collects a 16-byte password and compares it with a reference
// Assumes: first byte received is the most significant
// Notes:   match is combinational from the collected value
`timescale 1ns/1ps
`default_nettype none

module tfupv_pwd_match
	import tfupv_pkg::*;
#(
	parameter int PWD_BITS = 128
)
(
	input  wire logic                clock_i,  // system clock
	input  wire logic                rst_i,    // synchronous reset, high
	input  wire logic                clear_i,  // start of a new password
	input  wire logic                shift_i,  // take byte_i
	input  wire logic [7:0]          byte_i,   // password byte
	input  wire logic [PWD_BITS-1:0] ref_i,    // stored reference
	output logic                     match_o   // collected value equals ref_i
);

	tfupv_pwd_type r;
	tfupv_pwd_type next_r;

	always_comb
	begin
		next_r = r;
		if (clear_i)
			next_r.shift = '0;
		else if (shift_i)
			next_r.shift = {r.shift[119:0], byte_i};
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign match_o = (r.shift == ref_i);

endmodule

`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench of the command interpreter
// Assumes: memory commits after a chosen delay, host model on the stream side
// Notes:   short extension period keeps the long-commit case brief
`timescale 1ns/1ps
`default_nettype none

module tb;
	import tfupv_pkg::*;
	typedef logic [7:0] tfupv_q_type[$];
	localparam int WTX = 8;

	logic           clock_i, rst_i, tx_ready, mem_done, mem_ok, wtx, from_i2c;
	logic           sopen, selp, fsel, ndef, rprot, wprot, rg, wg, slow;
	tfupv_byte_type rx, tx;
	tfupv_mem_type  mem;
	logic [15:0]    flen;
	logic [127:0]   rpwd, wpwd, ipwd;
	logic [3:0]     ret;
	int             n_errors, n_tests, dly, dcnt, wtx_n, m_ret;
	bit             m_rg, m_wg;
	logic [23:0]    wr_q[$];

	tfupv_cmd #(.WTX_CYCLES(WTX)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .rx_i(rx),
		.tx_ready_i(tx_ready), .tx_o(tx), .mem_o(mem), .mem_done_i(mem_done),
		.mem_ok_i(mem_ok), .wtx_req_o(wtx), .from_i2c_i(from_i2c), .session_open_i(sopen),
		.select_i(selp), .file_sel_i(fsel), .ndef_sel_i(ndef), .file_len_i(flen),
		.read_prot_i(rprot), .write_prot_i(wprot), .read_pwd_i(rpwd), .write_pwd_i(wpwd),
		.i2c_pwd_i(ipwd), .read_grant_o(rg), .write_grant_o(wg), .retries_o(ret));

	tfupv_host u_host (.clock_i(clock_i), .slow_i(slow), .tx_i(tx), .rx_o(rx),
		.ready_o(tx_ready));

	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// memory side: records writes, ends each commit after dly cycles
	always @(posedge clock_i)
	begin
		mem_done <= 1'b0;
		if (wtx === 1'b1)
			wtx_n++;
		if (mem.we === 1'b1)
			wr_q.push_back({mem.addr, mem.wdata});
		if (mem.commit === 1'b1)
			dcnt <= dly;
		else if (dcnt == 1)
			mem_done <= 1'b1;
		if (mem.commit !== 1'b1 && dcnt > 0)
			dcnt <= dcnt - 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic tfupv_q_type frame(logic [7:0] cla, ins, logic [15:0] p,
		logic [7:0] lc, int n, logic [127:0] pw);
		tfupv_q_type q;
		q = {cla, ins, p[15:8], p[7:0], lc};
		for (int i = 0; i < n; i++)
			q.push_back(n == 16 ? pw[127 - 8 * i -: 8] : 8'($urandom));
		return q;
	endfunction

	task automatic model(input tfupv_q_type f, output logic [15:0] sw);
		int lc, p, n;
		logic [127:0] pw, rv;
		lc = f[4];
		p = {f[2], f[3]};
		n = f.size();
		if (f[0] != 8'h00)
			sw = 16'h6E00;
		else if (f[1] == 8'hD6)
		begin
			if (!fsel)
				sw = 16'h6A82;
			else if (lc == 0 || lc > 246 || p + lc > flen || n != 5 + lc)
				sw = 16'h6700;
			else if (ndef && wprot && !m_wg)
				sw = 16'h6982;
			else
				sw = mem_ok ? 16'h9000 : 16'h6581;
		end
		else if (f[1] != 8'h20)
			sw = 16'h6D00;
		else if (!fsel)
			sw = 16'h6985;
		else if (!ndef)
			sw = 16'h6981;
		else if (p < 1 || p > 3 || (p == 3 && !from_i2c))
			sw = 16'h6A80;
		else if (!from_i2c && m_ret == 0)
			sw = 16'h6982;
		else if (lc == 0)
			sw = (p == 1 && rprot && !m_rg) || (p == 2 && wprot && !m_wg) ? 16'h6300 : 16'h9000;
		else if (lc != 16 || n != 21)
			sw = 16'h6A80;
		else
		begin
			for (int i = 0; i < 16; i++)
				pw = {pw[119:0], f[5 + i]};
			rv = p == 1 ? rpwd : p == 2 ? wpwd : ipwd;
			if (pw == rv)
			begin
				sw = 16'h9000;
				m_ret = from_i2c ? m_ret : 3;
				m_rg |= p != 2;
				m_wg |= p != 1;
			end
			else
			begin
				m_ret -= from_i2c ? 0 : 1;
				sw = {8'h63, 4'hC, 4'(m_ret)};
			end
		end
	endtask

	task automatic run(input tfupv_q_type f, input int d);
		logic [15:0] e, s;
		logic [1:0] lf;
		model(f, e);
		dly = d;
		wr_q.delete();
		wtx_n = 0;
		u_host.send(f);
		u_host.get(s, lf);
		check(s, e);
		check(lf, 2'b01);
		check(ret, m_ret);
		check({wg, rg}, {m_wg, m_rg});
		if (f[1] == 8'hD6 && e == 16'h9000)
		begin
			check(wr_q.size(), f[4]);
			foreach (wr_q[k])
				check(wr_q[k], {16'({f[2], f[3]} + k), f[5 + k]});
			check(wtx_n > 0, d > WTX);
		end
	endtask

	task automatic cfg(input logic s, nd, wp, rp, i2, ok);
		@(posedge clock_i);
		{fsel, ndef, wprot, rprot, from_i2c, mem_ok} <= {s, nd, wp, rp, i2, ok};
		@(posedge clock_i);
	endtask

	task automatic pulse(input bit sess);
		@(posedge clock_i);
		{sopen, selp} <= {sess, !sess};
		@(posedge clock_i);
		{sopen, selp} <= 2'b00;
		{m_rg, m_wg} = 2'b00;
		m_ret = sess ? 3 : m_ret;
	endtask

	initial
	begin
		repeat (50000) @(posedge clock_i);
		n_errors++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(32'h787FA57A));
		{rst_i, mem_done, mem_ok, from_i2c, sopen, selp} = 6'h20;
		{fsel, ndef, rprot, wprot, slow} = '0;
		{n_errors, n_tests, dly, dcnt, wtx_n, m_rg, m_wg} = '0;
		m_ret = 3;
		flen = 16'h0100;
		rpwd = {4{$urandom}};
		wpwd = {4{$urandom}};
		ipwd = {4{$urandom}};
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		cfg(1, 1, 0, 0, 0, 1);
		run(frame(8'h00, 8'hD6, 16'h0010, 8'h08, 8, 0), 20);
		run(frame(8'h00, 8'hD6, 16'h00FC, 8'h04, 4, 0), 2);
		run(frame(8'h00, 8'hD6, 16'h00FD, 8'h04, 4, 0), 2);
		run(frame(8'h00, 8'hD6, 16'h0000, 8'hF6, 246, 0), 2);
		run(frame(8'h00, 8'hD6, 16'h0000, 8'hF7, 2, 0), 2);
		run(frame(8'h00, 8'hD6, 16'h0000, 8'h00, 0, 0), 2);
		run(frame(8'h10, 8'hD6, 16'h0000, 8'h01, 1, 0), 2);
		run(frame(8'h00, 8'h20, 16'h0002, 8'h00, 0, 0), 2);
		slow <= 1'b1;
		cfg(1, 1, 1, 1, 0, 0);
		run(frame(8'h00, 8'hD6, 16'h0000, 8'h02, 2, 0), 2);
		run(frame(8'h00, 8'h20, 16'h0001, 8'h00, 0, 0), 2);
		repeat (4)
			run(frame(8'h00, 8'h20, 16'h0002, 8'h10, 16, ~wpwd), 2);
		run(frame(8'h00, 8'h20, 16'h0002, 8'h00, 0, 0), 2);
		pulse(1);
		run(frame(8'h00, 8'h20, 16'h0002, 8'h10, 16, wpwd), 2);
		run(frame(8'h00, 8'hD6, 16'h0000, 8'h02, 2, 0), 2);
		pulse(0);
		run(frame(8'h00, 8'h20, 16'h0002, 8'h00, 0, 0), 2);
		cfg(1, 1, 1, 1, 1, 1);
		run(frame(8'h00, 8'h20, 16'h0003, 8'h10, 16, ~ipwd), 2);
		run(frame(8'h00, 8'h20, 16'h0003, 8'h10, 16, ipwd), 2);
		// reset mid-run drops the grants just won and restores retries
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		{m_rg, m_wg} = 2'b00;
		m_ret = 3;
		@(posedge clock_i);
		check({wg, rg, ret, tx.valid, mem.we, wtx}, {2'b00, 4'h3, 3'b000});
		cfg(1, 1, 0, 0, 0, 1);
		run(frame(8'h00, 8'h20, 16'h0003, 8'h10, 16, ipwd), 2);
		run(frame(8'h00, 8'h20, 16'h0004, 8'h00, 0, 0), 2);
		run(frame(8'h00, 8'h20, 16'h0001, 8'h05, 5, 0), 2);
		run(frame(8'h80, 8'h20, 16'h0001, 8'h00, 0, 0), 2);
		run(frame(8'h00, 8'hB0, 16'h0000, 8'h00, 0, 0), 2);
		cfg(1, 0, 0, 0, 0, 1);
		run(frame(8'h00, 8'h20, 16'h0001, 8'h00, 0, 0), 2);
		cfg(0, 0, 0, 0, 0, 1);
		run(frame(8'h00, 8'h20, 16'h0001, 8'h00, 0, 0), 2);
		run(frame(8'h00, 8'hD6, 16'h0000, 8'h01, 1, 0), 2);
		print_verdict();
	end
endmodule

`default_nettype wire

// File: tb/tfupv_host.sv
// Purpose: host model, sends command frames and takes status bytes
// Assumes: one frame in flight, next frame only after SW2 is taken
// Notes:   slow_i makes the host stall each response byte at random
`timescale 1ns/1ps
`default_nettype none

module tfupv_host
	import tfupv_pkg::*;
(
	input  wire logic           clock_i, // system clock
	input  wire logic           slow_i,  // stall responses at random
	input  wire tfupv_byte_type tx_i,    // response bytes
	output tfupv_byte_type      rx_o,    // command bytes
	output logic                ready_o  // response byte taken
);
	initial
	begin
		rx_o = '0;
		ready_o = 1'b0;
	end

	always @(posedge clock_i)
		ready_o <= slow_i ? 1'($urandom) : 1'b1;

	task automatic send(input logic [7:0] f[$]);
		foreach (f[i])
		begin
			@(posedge clock_i);
			rx_o <= '{1'b1, i == f.size() - 1, f[i]};
		end
		@(posedge clock_i);
		// stale byte inverted so a lax decoder cannot reuse it
		rx_o <= '{1'b0, 1'b0, ~f[f.size() - 1]};
	endtask

	task automatic get(output logic [15:0] sw, output logic [1:0] lf);
		int k;
		sw = '0;
		lf = '0;
		k = 0;
		for (int n = 0; n < 4000 && k < 2; n++)
		begin
			@(posedge clock_i);
			if (tx_i.valid === 1'b1 && ready_o === 1'b1)
			begin
				sw = {sw[7:0], tx_i.data};
				lf = {lf[0], tx_i.last};
				k++;
			end
		end
	endtask
endmodule

`default_nettype wire
